// [src/essq_sequencer.sv]
/*
  emergency-stop sequencer with register slave on axi4-lite.
  assumes a two-channel stop button and reset button on pins, an unsigned
  encoder speed magnitude on the system clock, one axi master.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module essq_sequencer import essq_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // button pins, active high when pressed
  input wire logic stop_ch_a_i,
  input wire logic stop_ch_b_i,
  input wire logic reset_btn_i,
  // encoder speed magnitude, same clock
  input wire logic [15:0] speed_i,
  input wire logic motor_stopped_i,
  // drive side
  output logic torque_off_o,
  output logic drive_fault_o,
  output logic lamp_o,
  output logic input_test_pulse_o,
  output logic irq_o,
  // axi4-lite write
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i
);
  // pin synchronisers, two stages each
  logic [2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {reset_btn_i, stop_ch_b_i, stop_ch_a_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire ch_a = pin_s2_q[0];
  wire ch_b = pin_s2_q[1];
  wire rst_btn = pin_s2_q[2];

  // register storage
  logic [31:0] ctrl_q, mon_q, zsd_q;
  logic [15:0] zsl_q, whi_q, wlo_q;
  logic [ESSQ_EV_W-1:0] ev_q, ev_d, msk_q;
  essq_cfg_t cfg_q; // configuration in use
  essq_state_t st_q, st_d;

  // test pulse generator: brief high pulses on stop circuit
  logic [19:0] tp_cnt_q;
  logic tp_q;
  wire tp_wrap = (tp_cnt_q == ESSQ_TP_PERIOD_CYC - 20'd1);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tp_cnt_q <= 20'h0;
      tp_q <= 1'b0;
    end else begin
      tp_cnt_q <= tp_wrap ? 20'h0 : tp_cnt_q + 20'd1;
      tp_q <= (tp_cnt_q < ESSQ_TP_WIDTH_CYC);
    end
  end
  // readings taken during and just after a pulse are masked
  wire tp_blank = (tp_cnt_q < ESSQ_TP_WIDTH_CYC + ESSQ_TP_SETTLE_CYC);

  // channel discrepancy timer
  logic [19:0] disc_q;
  wire mismatch = (ch_a != ch_b) && !tp_blank;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) disc_q <= 20'h0;
    else disc_q <= mismatch ? disc_q + 20'd1 : 20'h0;
  end
  wire redun_fault = (disc_q >= ESSQ_DISC_CYC);
  wire stop_req = (ch_a || ch_b) && !tp_blank;
  wire stop_rel = !ch_a && !ch_b && !tp_blank;

  // reset button rising edge
  logic rst_btn_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) rst_btn_q <= 1'b0;
    else rst_btn_q <= rst_btn;
  end
  wire rst_press = rst_btn && !rst_btn_q;

  // speed comparisons
  wire at_zero = (speed_i <= cfg_q.zs_lim);
  wire out_win = (speed_i > cfg_q.win_hi) || (speed_i < cfg_q.win_lo);

  // stop monitor and zero-speed delay counters
  logic [31:0] mon_cnt_q, zs_cnt_q;
  wire mon_exp = (mon_cnt_q == 32'h0);
  wire zs_done = (zs_cnt_q == 32'h0);
  wire time_mode = (cfg_q.mode == ESSQ_MODE_TIME);
  wire ramp_mode = (cfg_q.mode == ESSQ_MODE_RAMP);

  // next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RUN: begin
        if (redun_fault) st_d = ST_REDUN;
        else if (stop_req && cfg_q.mode == ESSQ_MODE_CAT0)
          st_d = ST_LIMIT;
        else if (stop_req) st_d = ST_DECEL;
      end
      ST_DECEL: begin
        if (redun_fault) st_d = ST_REDUN;
        else if (at_zero) st_d = ST_ZS_WAIT;
        else if (time_mode && mon_exp) st_d = ST_LIMIT;
        else if (ramp_mode && out_win) st_d = ST_LIMIT;
      end
      ST_ZS_WAIT: begin
        if (redun_fault) st_d = ST_REDUN;
        else if (zs_done) st_d = ST_STOPPED;
      end
      ST_STOPPED, ST_ACK_OK: begin
        // expiry of the monitor timer is ignored here
        if (redun_fault) st_d = ST_REDUN;
        else if (rst_press && stop_rel) st_d = ST_RUN;
      end
      ST_LIMIT: begin
        if (at_zero) st_d = ST_ACK_OK;
      end
      ST_REDUN: begin
        if (!mismatch && disc_q == 20'h0 && at_zero && stop_rel
            && rst_press) st_d = ST_RUN;
      end
      default: st_d = ST_REDUN;
    endcase
  end
  // presses in states other than ST_STOPPED, ST_ACK_OK and ST_REDUN fall through unchanged

  // state, counters, configuration sample
  wire cfg_load = (st_q == ST_RUN) && motor_stopped_i;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= ST_RUN;
      mon_cnt_q <= 32'h0;
      zs_cnt_q <= 32'h0;
      cfg_q <= '0;
    end else begin
      st_q <= st_d;
      if (cfg_load) cfg_q <= {ctrl_q[1:0], ctrl_q[ESSQ_CTRL_FSEL], mon_q,
                              zsd_q, zsl_q, whi_q, wlo_q};
      if (st_q == ST_RUN) mon_cnt_q <= cfg_q.mon_dly;
      else if (!mon_exp) mon_cnt_q <= mon_cnt_q - 32'd1;
      if (st_q != ST_ZS_WAIT) zs_cnt_q <= cfg_q.zs_dly;
      else if (!zs_done) zs_cnt_q <= zs_cnt_q - 32'd1;
    end
  end

  // outputs from flops
  wire sto_d = (st_d != ST_RUN) && (st_d != ST_DECEL) && (st_d != ST_ZS_WAIT);
  wire lamp_d = (st_d == ST_STOPPED) || (st_d == ST_ACK_OK);
  wire limit_ev = (st_d == ST_LIMIT) && (st_q != ST_LIMIT);
  logic fault_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      torque_off_o <= 1'b0;
      lamp_o <= 1'b0;
      fault_q <= 1'b0;
      input_test_pulse_o <= 1'b0;
    end else begin
      torque_off_o <= sto_d;
      lamp_o <= lamp_d;
      input_test_pulse_o <= tp_q;
      // drive clears its own copy; ours holds until the next run
      if (limit_ev && st_q != ST_RUN && cfg_q.fault_sel) fault_q <= 1'b1;
      else if (st_q == ST_RUN && st_d == ST_RUN) fault_q <= 1'b0;
    end
  end
  always_comb drive_fault_o = fault_q;

  // event capture, set wins over read-clear
  wire [ESSQ_EV_W-1:0] ev_set = {
    (st_q == ST_ACK_OK || st_q == ST_STOPPED) && st_d == ST_RUN,
    st_d == ST_REDUN && st_q != ST_REDUN, limit_ev,
    st_q == ST_RUN && st_d != ST_RUN};
  logic ev_rd_clr;
  always_comb ev_d = (ev_rd_clr ? '0 : ev_q) | ev_set;

  // axi4-lite write path
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  wire do_wr = aw_hold_q && w_hold_q && !s_bvalid_o;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= 2'h0;
      ctrl_q <= ESSQ_CTRL_RST;
      mon_q <= 32'h0;
      zsd_q <= 32'h0;
      zsl_q <= 16'h0;
      whi_q <= 16'hffff;
      wlo_q <= 16'h0;
      msk_q <= '0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_wdata_i;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= 2'h0;
        unique case (aw_addr_q)
          ESSQ_CTRL: ctrl_q <= w_data_q;
          ESSQ_MON_DLY: mon_q <= w_data_q;
          ESSQ_ZS_DLY: zsd_q <= w_data_q;
          ESSQ_ZS_LIM: zsl_q <= w_data_q[15:0];
          ESSQ_WIN_HI: whi_q <= w_data_q[15:0];
          ESSQ_WIN_LO: wlo_q <= w_data_q[15:0];
          ESSQ_IRQ_MSK: msk_q <= w_data_q[ESSQ_EV_W-1:0];
          ESSQ_STATE, ESSQ_IRQ_ST: ;
          default: s_bresp_o <= 2'h2;
        endcase
      end else if (s_bvalid_o && s_bready_i) s_bvalid_o <= 1'b0;
    end
  end
  always_comb s_awready_o = !aw_hold_q;
  always_comb s_wready_o = !w_hold_q;

  // axi4-lite read path
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_araddr_i)
      ESSQ_CTRL: rd_mux = ctrl_q;
      ESSQ_MON_DLY: rd_mux = mon_q;
      ESSQ_ZS_DLY: rd_mux = zsd_q;
      ESSQ_ZS_LIM: rd_mux = {16'h0, zsl_q};
      ESSQ_WIN_HI: rd_mux = {16'h0, whi_q};
      ESSQ_WIN_LO: rd_mux = {16'h0, wlo_q};
      ESSQ_STATE: rd_mux = {22'h0, fault_q, torque_off_o, 1'b0, st_q};
      ESSQ_IRQ_ST: rd_mux = {28'h0, ev_q};
      ESSQ_IRQ_MSK: rd_mux = {28'h0, msk_q};
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_comb s_arready_o = !s_rvalid_o;
  always_comb ev_rd_clr = s_arvalid_i && s_arready_o
                          && s_araddr_i == ESSQ_IRQ_ST;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0;
      s_rresp_o <= 2'h0;
      ev_q <= '0;
      irq_o <= 1'b0;
    end else begin
      ev_q <= ev_d;
      irq_o <= |(ev_d & msk_q);
      if (s_arvalid_i && s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rdata_o <= rd_mux;
        s_rresp_o <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_rready_i) s_rvalid_o <= 1'b0;
    end
  end

  // checks
  limit_sto_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_LIMIT |-> torque_off_o) else $error("no torque-off");
  ramp_exit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_DECEL && ramp_mode && !at_zero && out_win && !redun_fault
    |=> st_q == ST_LIMIT) else $error("window exit missed");
  ack_lamp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_ACK_OK |-> lamp_o) else $error("lamp off at ack");
  release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_RUN && $past(st_q) == ST_ACK_OK |-> !torque_off_o && !lamp_o)
    else $error("release wrong");
  early_reset_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_LIMIT && rst_press && !at_zero |=> st_q == ST_LIMIT)
    else $error("early reset taken");
  cat0_sto_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_RUN && stop_req && cfg_q.mode == ESSQ_MODE_CAT0
    |=> torque_off_o) else $error("cat0 slow");
  decel_free_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_DECEL |-> !torque_off_o) else $error("early sto");
  zs_delay_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_ZS_WAIT && !zs_done && !redun_fault |=> st_q == ST_ZS_WAIT)
    else $error("delay skipped");
  redun_sto_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_REDUN |-> torque_off_o) else $error("redun open");
  cfg_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q != ST_RUN |=> $stable(cfg_q)) else $error("cfg moved");
  limit_c: cover property (@(posedge clk_i) st_q == ST_LIMIT);
  zs_c: cover property (@(posedge clk_i) st_q == ST_STOPPED);
  redun_c: cover property (@(posedge clk_i) st_q == ST_REDUN);
endmodule : essq_sequencer
`default_nettype wire

// [src/essq_pkg.sv]
/*
  package for the emergency-stop safe-stop sequencer: register map,
  field positions, reset values, timing counts and shared types.
  assumes a single 200 MHz clock and a synchronous active-low reset.
*/
// Function
// - time mode: stop starts sequence and timer
// - zero speed in timer: torque-off, lamp on
// - optional extra delay before torque-off
// - timer expiry after torque-off does nothing
// - expiry above zero speed: limit hit, torque-off
// - after limit hit, lamp and ack at zero
// - reset press when permitted acknowledges stop
// - acknowledge releases torque-off, lamp off
// - limit hit raises fault to drive
// - ramp mode: drive ramps, device checks window
// - ramp mode zero speed: torque-off, lamp on
// - ramp mode window exit: limit hit, torque-off
// - category 0: immediate torque-off
// - category 1: decelerate first, then torque-off
// - restart needs release, reset, fault reset, start
// - drive test pulses onto stop inputs
// - channel mismatch is redundancy fault, torque-off
package essq_pkg;
  // register byte offsets
  localparam logic [7:0] ESSQ_CTRL = 8'h00; // mode, fault select
  localparam logic [7:0] ESSQ_MON_DLY = 8'h04; // stop monitor delay
  localparam logic [7:0] ESSQ_ZS_DLY = 8'h08; // zero-speed torque-off delay
  localparam logic [7:0] ESSQ_ZS_LIM = 8'h0c; // zero speed limit
  localparam logic [7:0] ESSQ_WIN_HI = 8'h10; // ramp window upper
  localparam logic [7:0] ESSQ_WIN_LO = 8'h14; // ramp window lower
  localparam logic [7:0] ESSQ_STATE = 8'h18; // live state
  localparam logic [7:0] ESSQ_IRQ_ST = 8'h1c; // sticky events
  localparam logic [7:0] ESSQ_IRQ_MSK = 8'h20; // event mask
  // ctrl fields
  localparam int ESSQ_CTRL_MODE_LSB = 0; // two bits
  localparam int ESSQ_CTRL_FSEL = 2; // limit-hit fault select
  localparam logic [31:0] ESSQ_CTRL_RST = 32'h0000_0005;
  // stop modes
  localparam logic [1:0] ESSQ_MODE_CAT0 = 2'h0;
  localparam logic [1:0] ESSQ_MODE_TIME = 2'h1;
  localparam logic [1:0] ESSQ_MODE_RAMP = 2'h2;
  // event bits
  localparam int ESSQ_EV_STOP = 0;
  localparam int ESSQ_EV_LIMIT = 1;
  localparam int ESSQ_EV_REDUN = 2;
  localparam int ESSQ_EV_ACK = 3;
  localparam int ESSQ_EV_W = 4;
  // timing: test pulse period and width, redundancy tolerance
  localparam int ESSQ_CLK_MHZ = 200;
  localparam int ESSQ_TP_PERIOD_US = 1000;
  localparam int ESSQ_TP_WIDTH_US = 1;
  localparam int ESSQ_DISC_US = 10;
  localparam logic [19:0] ESSQ_TP_PERIOD_CYC =
    20'(ESSQ_TP_PERIOD_US * ESSQ_CLK_MHZ);
  localparam logic [19:0] ESSQ_TP_WIDTH_CYC =
    20'(ESSQ_TP_WIDTH_US * ESSQ_CLK_MHZ);
  localparam logic [19:0] ESSQ_DISC_CYC = 20'(ESSQ_DISC_US * ESSQ_CLK_MHZ);
  localparam logic [19:0] ESSQ_TP_SETTLE_CYC = 20'd8;
  // configuration bundle sampled while stopped
  typedef struct packed {
    logic [1:0] mode;
    logic fault_sel;
    logic [31:0] mon_dly;
    logic [31:0] zs_dly;
    logic [15:0] zs_lim;
    logic [15:0] win_hi;
    logic [15:0] win_lo;
  } essq_cfg_t;
  // sequencer states
  typedef enum logic [6:0] {
    ST_RUN = 7'h01,
    ST_DECEL = 7'h02,
    ST_ZS_WAIT = 7'h04,
    ST_STOPPED = 7'h08,
    ST_LIMIT = 7'h10,
    ST_ACK_OK = 7'h20,
    ST_REDUN = 7'h40
  } essq_state_t;
endpackage : essq_pkg

// [bench/essq_drive_model.sv]
/*
  drive model for the sequencer bench: ramps, coasts and latches faults.
  assumes the bench gives start, stop, fault reset and a ramp rate.
*/
`timescale 1ns/1ps
`default_nettype none
module essq_drive_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // operator commands
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic fault_rst_i,
  input wire logic [15:0] rate_i,
  // from the sequencer
  input wire logic torque_off_i,
  input wire logic fault_i,
  // to the sequencer
  output logic [15:0] speed_o,
  output logic stopped_o
);
  logic run_q; // motor driven
  logic flt_q; // latched drive fault
  logic [15:0] dec; // speed step down
  // no torque means coasting, slower than the ramp
  assign dec = torque_off_i ? 16'h0001 : rate_i;
  assign stopped_o = (speed_o == 16'h0000);
  // fault holds until the drive's own reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) flt_q <= 1'b0;
    else if (fault_i) flt_q <= 1'b1;
    else if (fault_rst_i) flt_q <= 1'b0;
  end
  // a start is refused while stopped or faulted
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || stop_i || torque_off_i) run_q <= 1'b0;
    else if (start_i && !flt_q) run_q <= 1'b1;
  end
  // speed ramps up to 1000 or down to zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) speed_o <= 16'h0000;
    else if (run_q)
      speed_o <= (speed_o < 16'd1000) ? speed_o + 16'd10 : speed_o;
    else speed_o <= (speed_o > dec) ? speed_o - dec : 16'h0000;
  end
endmodule : essq_drive_model
`default_nettype wire

// [bench/tb.sv]
/*
  top bench: axi4-lite master tasks, drive model and stop scenarios.
  assumes the design package and the drive model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import essq_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, stp = 1'b0, rbtn = 1'b0;
  logic go = 1'b0, frst = 1'b0, mst, toff, flt, lamp, irq, tp;
  logic [15:0] rate = 16'd20, spd;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, seed = 8'h4a;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awrdy, wrdy, bvld, arrdy, rvld;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q[$]; // expected {rresp, rdata}
  logic [33:0] exp_e;
  int fail_count = 0, checked = 0;
  // clock at 200 mhz
  initial forever #2.5 clk_i = ~clk_i;
  essq_sequencer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .stop_ch_a_i(stp),
    .stop_ch_b_i(stp), .reset_btn_i(rbtn), .speed_i(spd),
    .motor_stopped_i(mst), .torque_off_o(toff), .drive_fault_o(flt),
    .lamp_o(lamp), .input_test_pulse_o(tp), .irq_o(irq),
    .s_awaddr_i(awaddr), .s_awvalid_i(awv), .s_awready_o(awrdy),
    .s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wv), .s_wready_o(wrdy),
    .s_bresp_o(bresp), .s_bvalid_o(bvld), .s_bready_i(bre),
    .s_araddr_i(araddr), .s_arvalid_i(arv), .s_arready_o(arrdy),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvld),
    .s_rready_i(rre));
  essq_drive_model drv (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(go),
    .stop_i(stp), .fault_rst_i(frst), .rate_i(rate), .torque_off_i(toff),
    .fault_i(flt), .speed_o(spd), .stopped_o(mst));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // 0 torque off, 1 lamp, 2 fault, 3 irq, else speed below limit
  function automatic logic probe(input int s);
    case (s)
      0: return toff;
      1: return lamp;
      2: return flt;
      3: return irq;
      default: return spd < 16'd5;
    endcase
  endfunction : probe
  // read data checked against the oldest note
  always @(posedge clk_i) begin
    if (rvld && rre && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      `CHK({rresp, rdata}, exp_e)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit dn;
    n = 0;
    dn = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!dn && n < 100) begin
      @(posedge clk_i);
      n++;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bvld && bre) begin
        bre <= 1'b0;
        dn = 1;
        `CHK(bresp, 2'b00)
      end
    end
    if (!dn) fail_count++;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    bit dn;
    n = 0;
    dn = 0;
    exp_q.push_back(e);
    @(posedge clk_i);
    araddr <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    while (!dn && n < 100) begin
      @(posedge clk_i);
      n++;
      if (arv && arrdy) arv <= 1'b0;
      if (rvld && rre) begin
        rre <= 1'b0;
        dn = 1;
      end
    end
    if (!dn) fail_count++;
  endtask : rd
  task automatic wait_to(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (probe(s) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(probe(s), v)
  endtask : wait_to
  // mode, monitor delay, zero-speed delay, window top; limit 5
  task automatic cfg(input logic [31:0] c, m, z, h);
    wr(ESSQ_CTRL, c);
    wr(ESSQ_MON_DLY, m);
    wr(ESSQ_ZS_DLY, z);
    wr(ESSQ_ZS_LIM, 32'd5);
    wr(ESSQ_WIN_HI, h);
    repeat (10) @(posedge clk_i);
  endtask : cfg
  task automatic pulse(input int s);
    @(posedge clk_i);
    if (s == 0) go <= 1'b1;
    else if (s == 1) frst <= 1'b1;
    else rbtn <= 1'b1;
    repeat (10) @(posedge clk_i);
    {go, frst, rbtn} <= 3'b000;
    repeat (10) @(posedge clk_i);
  endtask : pulse
  // random ramp rate, then run up to full speed
  task automatic spin();
    seed = lfsr(seed);
    rate <= 16'(seed[3:0]) + 16'd8;
    pulse(0);
    repeat (110) @(posedge clk_i);
  endtask : spin
  task automatic rst_all();
    stp <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (50) @(posedge clk_i);
    `CHK(tp, 1'b1)
    repeat (250) @(posedge clk_i); // past input blanking
    `CHK(tp, 1'b0)
    `CHK({toff, lamp, flt, irq}, 4'h0)
  endtask : rst_all
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_all();
    rd(ESSQ_CTRL, {2'b00, ESSQ_CTRL_RST});
    rd(ESSQ_WIN_HI, 34'h0_0000_ffff);
    rd(8'h40, 34'h2_0000_0000);
    $display("test registers done");
    cfg(32'h1, 32'd3000, 32'd0, 32'hffff);
    spin();
    stp <= 1'b1;
    wait_to(4, 1'b1, 400);
    wait_to(0, 1'b1, 20);
    wait_to(1, 1'b1, 5);
    repeat (3200) @(posedge clk_i);
    `CHK({toff, flt, irq}, 3'b100)
    stp <= 1'b0;
    pulse(2);
    wait_to(0, 1'b0, 30);
    wait_to(1, 1'b0, 5);
    $display("test time mode done");
    wr(ESSQ_IRQ_MSK, 32'h2);
    rd(ESSQ_IRQ_ST, 34'h9);
    cfg(32'h5, 32'd20, 32'd0, 32'hffff);
    spin();
    stp <= 1'b1;
    wait_to(0, 1'b1, 40);
    `CHK(probe(4), 1'b0)
    wait_to(2, 1'b1, 5);
    wait_to(3, 1'b1, 5);
    rd(ESSQ_STATE, 34'h310);
    rd(ESSQ_IRQ_ST, 34'h3);
    wait_to(3, 1'b0, 5);
    pulse(2);
    `CHK({toff, lamp}, 2'b10)
    stp <= 1'b0;
    wait_to(4, 1'b1, 2000);
    wait_to(1, 1'b1, 10);
    pulse(2);
    wait_to(0, 1'b0, 30);
    pulse(0);
    repeat (30) @(posedge clk_i);
    `CHK(spd, 16'h0)
    pulse(1);
    pulse(0);
    repeat (30) @(posedge clk_i);
    `CHK(probe(4), 1'b0)
    $display("test limit hit done");
    rst_all();
    cfg(32'h2, 32'd0, 32'd40, 32'hffff);
    spin();
    stp <= 1'b1;
    wait_to(4, 1'b1, 400);
    repeat (20) @(posedge clk_i);
    `CHK(toff, 1'b0)
    wait_to(0, 1'b1, 60);
    wait_to(1, 1'b1, 5);
    stp <= 1'b0;
    pulse(2);
    wait_to(0, 1'b0, 30);
    cfg(32'h2, 32'd0, 32'd0, 32'd100);
    spin();
    stp <= 1'b1;
    wait_to(0, 1'b1, 12);
    `CHK(probe(4), 1'b0)
    $display("test ramp mode done");
    rst_all();
    cfg(32'h0, 32'd0, 32'd0, 32'hffff);
    spin();
    stp <= 1'b1;
    wait_to(0, 1'b1, 10);
    `CHK(probe(4), 1'b0)
    $display("test category 0 done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
